/* logic/pra_agu.sv */
/*
 Operand address generator for symbolic (program counter relative) and
 absolute modes, source and destination. Assumes the fetch logic presents
 a decoded instruction with start, a memory port answering with mem_ack in
 the same or a later cycle, and the datapath reading results on done.
*/
// Functional notes
// - Relative address is program counter plus index
// - Lower bank base instruction clears bits 19:16
// - Base index is next word, result 16-bit
// - Upper bank: sign-extend index, add 20 bits
// - Upper bank sum wraps freely in 20 bits
// - Base is the index word's own address
// - Extended relative adds full 20-bit index
// - Extended index: four bits extension, sixteen next
// - Instruction length counts extension and index words
// - Source and destination each get own index
// - Absolute uses index word directly from zero
// - Base absolute address stays in lower bank
// - Extended absolute joins four plus sixteen bits
// - Operand read from computed address, counter untouched
// - Relative selected by indexed code with counter
// - Absolute selected by indexed code with status
// - Address-word data when flag pair is 01
`timescale 1ns/1ps
`default_nettype none

module pra_agu (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [19:0] program_counter,
    input wire logic is_extended,
    input wire logic len_flag,
    input wire logic byte_word,
    input wire logic [1:0] src_mode,
    input wire logic [3:0] src_reg,
    input wire logic dst_mode,
    input wire logic [3:0] dst_reg,
    input wire logic [3:0] src_index_hi,
    input wire logic [3:0] dst_index_hi,
    output logic busy,
    output logic mem_req,
    output logic [19:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    output logic done,
    output logic src_valid,
    output logic dst_valid,
    output logic [19:0] src_addr,
    output logic [19:0] dst_addr,
    output logic [19:0] src_operand,
    output logic [19:0] dst_operand,
    output logic [2:0] insn_words
);

    // ------------------------------------------------------------
    // Address arithmetic
    // ------------------------------------------------------------
    function automatic logic [19:0] pra_ea(
        input logic ext,
        input logic rel,
        input logic [19:0] base,
        input logic [15:0] lo,
        input logic [3:0] hi
    );
        logic [19:0] sum;
        sum = 20'h0_0000;
        if (rel) begin
            if (ext) begin
                sum = base + {hi, lo};
            end else if (base[19:16] == pra_pkg::LOWER_BANK) begin
                // bank chosen by index word address
                sum = {pra_pkg::LOWER_BANK, base[15:0] + lo};
            end else begin
                sum = base + {{4{lo[15]}}, lo};
            end
        end else if (ext) begin
            sum = {hi, lo};
        end else begin
            sum = {pra_pkg::LOWER_BANK, lo};
        end
        return sum;
    endfunction

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    // Other indexed base registers are left to the general indexed unit.
    logic src_rel;
    logic src_abs;
    logic dst_rel;
    logic dst_abs;
    logic addr_word;

    assign src_rel = (src_mode == pra_pkg::SRC_MODE_INDEXED) &&
                     (src_reg == pra_pkg::REG_PROGRAM_COUNTER);
    assign src_abs = (src_mode == pra_pkg::SRC_MODE_INDEXED) &&
                     (src_reg == pra_pkg::REG_STATUS_REGISTER);
    assign dst_rel = (dst_mode == pra_pkg::DST_MODE_INDEXED) &&
                     (dst_reg == pra_pkg::REG_PROGRAM_COUNTER);
    assign dst_abs = (dst_mode == pra_pkg::DST_MODE_INDEXED) &&
                     (dst_reg == pra_pkg::REG_STATUS_REGISTER);
    assign addr_word = is_extended && ({len_flag, byte_word} == pra_pkg::LEN_ADDR_WORD);

    // ------------------------------------------------------------
    // Captured instruction
    // ------------------------------------------------------------
    logic ext_q;
    logic aw_q;
    logic src_rel_q;
    logic dst_rel_q;
    logic src_use_q;
    logic dst_use_q;
    logic [3:0] src_hi_q;
    logic [3:0] dst_hi_q;
    logic [19:0] fetch_ptr_q;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ext_q <= 1'b0;
            aw_q <= 1'b0;
            src_rel_q <= 1'b0;
            dst_rel_q <= 1'b0;
            src_use_q <= 1'b0;
            dst_use_q <= 1'b0;
            src_hi_q <= 4'h0;
            dst_hi_q <= 4'h0;
        end else if (start && !busy) begin
            ext_q <= is_extended;
            aw_q <= addr_word;
            src_rel_q <= src_rel;
            dst_rel_q <= dst_rel;
            src_use_q <= src_rel || src_abs;
            dst_use_q <= dst_rel || dst_abs;
            src_hi_q <= src_index_hi;
            dst_hi_q <= dst_index_hi;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    pra_pkg::pra_state_type state_q;
    pra_pkg::pra_state_type state_d;
    logic take;

    assign take = mem_req && mem_ack;
    assign busy = (state_q != pra_pkg::ST_IDLE);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            pra_pkg::ST_IDLE: begin
                if (start) begin
                    state_d = (src_rel || src_abs) ? pra_pkg::ST_SRC_IX :
                              (dst_rel || dst_abs) ? pra_pkg::ST_DST_IX : pra_pkg::ST_DONE;
                end
            end
            pra_pkg::ST_SRC_IX: begin
                state_d = take ? pra_pkg::ST_SRC_LO : state_q;
            end
            pra_pkg::ST_SRC_LO: begin
                if (take) begin
                    state_d = aw_q ? pra_pkg::ST_SRC_HI :
                              dst_use_q ? pra_pkg::ST_DST_IX : pra_pkg::ST_DONE;
                end
            end
            pra_pkg::ST_SRC_HI: begin
                if (take) begin
                    state_d = dst_use_q ? pra_pkg::ST_DST_IX : pra_pkg::ST_DONE;
                end
            end
            pra_pkg::ST_DST_IX: begin
                state_d = take ? pra_pkg::ST_DST_LO : state_q;
            end
            pra_pkg::ST_DST_LO: begin
                state_d = !take ? state_q : (aw_q ? pra_pkg::ST_DST_HI : pra_pkg::ST_DONE);
            end
            pra_pkg::ST_DST_HI: begin
                state_d = take ? pra_pkg::ST_DONE : state_q;
            end
            pra_pkg::ST_DONE: begin
                state_d = pra_pkg::ST_IDLE;
            end
            default: begin
                state_d = pra_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= pra_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Index word pointer
    // ------------------------------------------------------------
    // pointer holds the index word address
    // private copy, the real counter is never written
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fetch_ptr_q <= 20'h0_0000;
        end else if (start && !busy) begin
            fetch_ptr_q <= program_counter + pra_pkg::WORD_STEP;
        end else if (take && (state_q == pra_pkg::ST_SRC_IX)) begin
            fetch_ptr_q <= fetch_ptr_q + pra_pkg::WORD_STEP;
        end
    end

    // ------------------------------------------------------------
    // Memory port
    // ------------------------------------------------------------
    logic [19:0] src_ea;
    logic [19:0] dst_ea;

    assign src_ea = pra_ea(ext_q, src_rel_q, fetch_ptr_q, mem_rdata, src_hi_q);
    assign dst_ea = pra_ea(ext_q, dst_rel_q, fetch_ptr_q, mem_rdata, dst_hi_q);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mem_req <= 1'b0;
            mem_addr <= 20'h0_0000;
        end else begin
            unique case (state_d)
                pra_pkg::ST_SRC_IX,
                pra_pkg::ST_DST_IX: begin
                    mem_req <= 1'b1;
                    mem_addr <= busy ? fetch_ptr_q : program_counter + pra_pkg::WORD_STEP;
                end
                pra_pkg::ST_SRC_LO: begin
                    mem_req <= 1'b1;
                    if (state_q == pra_pkg::ST_SRC_IX) begin
                        mem_addr <= src_ea;
                    end
                end
                pra_pkg::ST_DST_LO: begin
                    mem_req <= 1'b1;
                    if (state_q == pra_pkg::ST_DST_IX) begin
                        mem_addr <= dst_ea;
                    end
                end
                pra_pkg::ST_SRC_HI,
                pra_pkg::ST_DST_HI: begin
                    mem_req <= 1'b1;
                    if (state_q != state_d) begin
                        mem_addr <= mem_addr + pra_pkg::WORD_STEP;
                    end
                end
                default: begin
                    mem_req <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Results
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            src_addr <= 20'h0_0000;
            dst_addr <= 20'h0_0000;
            src_operand <= 20'h0_0000;
            dst_operand <= 20'h0_0000;
            src_valid <= 1'b0;
            dst_valid <= 1'b0;
        end else if (start && !busy) begin
            src_valid <= 1'b0;
            dst_valid <= 1'b0;
        end else if (take) begin
            unique case (state_q)
                pra_pkg::ST_SRC_IX: begin
                    src_addr <= src_ea;
                end
                pra_pkg::ST_DST_IX: begin
                    dst_addr <= dst_ea;
                end
                pra_pkg::ST_SRC_LO: begin
                    // operand is memory content at the address
                    src_operand <= {4'h0, mem_rdata};
                    src_valid <= 1'b1;
                end
                pra_pkg::ST_DST_LO: begin
                    dst_operand <= {4'h0, mem_rdata};
                    dst_valid <= 1'b1;
                end
                pra_pkg::ST_SRC_HI: begin
                    src_operand <= {mem_rdata[3:0], src_operand[15:0]};
                end
                pra_pkg::ST_DST_HI: begin
                    dst_operand <= {mem_rdata[3:0], dst_operand[15:0]};
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Completion and length
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            done <= 1'b0;
            insn_words <= 3'h0;
        end else begin
            done <= (state_d == pra_pkg::ST_DONE);
            if (start && !busy) begin
                // one word each for extension and each index
                insn_words <= 3'h1 + {2'h0, is_extended} + {2'h0, src_rel || src_abs} +
                              {2'h0, dst_rel || dst_abs};
            end
        end
    end

endmodule

`default_nettype wire

/* pkg/pra_pkg.sv */
/*
 Shared constants and types of the program-counter-relative and absolute
 operand address generator. Assumes a 20-bit byte address space and a
 16-bit memory data bus.
*/
`default_nettype none

package pra_pkg;

    // ------------------------------------------------------------
    // Widths and address arithmetic
    // ------------------------------------------------------------
    localparam int ADDR_WIDTH = 20;
    localparam int WORD_WIDTH = 16;
    localparam logic [19:0] WORD_STEP = 20'h0_0002;
    localparam logic [3:0] LOWER_BANK = 4'h0;

    // ------------------------------------------------------------
    // Addressing field codes
    // ------------------------------------------------------------
    localparam logic [1:0] SRC_MODE_INDEXED = 2'h1;
    localparam logic DST_MODE_INDEXED = 1'b1;
    localparam logic [3:0] REG_PROGRAM_COUNTER = 4'h0;
    localparam logic [3:0] REG_STATUS_REGISTER = 4'h2;
    localparam logic [1:0] LEN_ADDR_WORD = 2'h1;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [7:0] {
        ST_IDLE   = 8'h01,
        ST_SRC_IX = 8'h02,
        ST_SRC_LO = 8'h04,
        ST_SRC_HI = 8'h08,
        ST_DST_IX = 8'h10,
        ST_DST_LO = 8'h20,
        ST_DST_HI = 8'h40,
        ST_DONE   = 8'h80
    } pra_state_type;

endpackage

`default_nettype wire

/* verification/pra_agu_asserts.sv */
/*
 Concurrent checks on the relative and absolute address generator.
 Assumes binding onto pra_agu, one clock, asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module pra_agu_asserts (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [19:0] program_counter,
    input wire logic is_extended,
    input wire logic [1:0] src_mode,
    input wire logic [3:0] src_reg,
    input wire logic dst_mode,
    input wire logic [3:0] dst_reg,
    input wire logic busy,
    input wire logic mem_req,
    input wire logic [19:0] mem_addr,
    input wire logic mem_ack,
    input wire logic done,
    input wire logic src_valid,
    input wire logic dst_valid,
    input wire logic [19:0] src_addr,
    input wire logic [19:0] dst_addr,
    input wire logic [2:0] insn_words
);
    // ----------------------------------------------
    // Properties
    // ----------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    wire logic take = start && !busy;
    wire logic sx = src_mode == 2'h1 && (src_reg == 4'h0 || src_reg == 4'h2);
    wire logic dx = dst_mode && (dst_reg == 4'h0 || dst_reg == 4'h2);
    wire logic [2:0] words_w = 3'h1 + 3'(is_extended) + 3'(sx) + 3'(dx);
    wire logic [19:0] ix_a = program_counter + 20'h0_0002;
    logic ext_q;
    logic low_q;
    // Bank judged on the index word, not the opcode
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ext_q <= 1'h0;
            low_q <= 1'h0;
        end else if (take) begin
            ext_q <= is_extended;
            low_q <= ix_a[19:16] == 4'h0;
        end
    end
    AST_TAKE_BUSY: assert property (
        take |=> busy) else $error("busy missing after start");
    AST_DONE_PULSE: assert property (
        done |=> !done && !busy) else $error("done longer than one cycle");
    AST_REQ_HOLD: assert property (
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr)) else $error("read dropped");
    AST_FIRST_ADDR: assert property (
        take && (sx || dx) |=> mem_req && mem_addr == $past(program_counter) + 20'h0_0002)
        else $error("index word address wrong");
    AST_NO_READ: assert property (
        take && !sx && !dx |=> done && !mem_req) else $error("no-operand timing wrong");
    AST_VALID_CLEAR: assert property (
        take |=> !src_valid && !dst_valid) else $error("valid flags not cleared");
    AST_WORDS: assert property (
        take |=> insn_words == $past(words_w)) else $error("instruction length wrong");
    AST_LOW_BANK: assert property (
        done && !ext_q && low_q |-> (!src_valid || src_addr[19:16] == 4'h0)
        && (!dst_valid || dst_addr[19:16] == 4'h0)) else $error("lower bank escaped");
    AST_IDLE_NO_REQ: assert property (
        !busy |-> !mem_req) else $error("read outside a sequence");
    cover property (done && src_valid && dst_valid);
    cover property (mem_req && !mem_ack ##1 mem_req && !mem_ack);
    cover property (start && busy);
endmodule

bind pra_agu pra_agu_asserts pra_agu_asserts_inst (.*);

`default_nettype wire

/* verification/pra_mem_model.sv */
/*
 Word memory answering the generator's reads after a set wait.
 Assumes the bench loads mem by hierarchy before each instruction.
*/
`timescale 1ns/1ps
`default_nettype none

module pra_mem_model (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic mem_req,
    input wire logic [19:0] mem_addr,
    input wire logic [3:0] wait_cycles,
    output logic mem_ack,
    output logic [15:0] mem_rdata
);
    // ----------------------------------------------
    // Read port
    // ----------------------------------------------
    logic [15:0] mem [logic [19:0]];
    logic [3:0] wait_q;
    // Data toggles outside an ack, so stale words never match
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wait_q <= 4'h0;
            mem_ack <= 1'h0;
            mem_rdata <= 16'h0;
        end else if (mem_req && !mem_ack && wait_q >= wait_cycles) begin
            wait_q <= 4'h0;
            mem_ack <= 1'h1;
            mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : ~mem_rdata;
        end else begin
            wait_q <= (mem_req && !mem_ack) ? wait_q + 4'h1 : 4'h0;
            mem_ack <= 1'h0;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

`default_nettype wire

/* verification/tb.sv */
/*
 Self-checking bench for the relative and absolute address generator.
 Assumes the memory model beside it; addresses are worked out by hand.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
    // ----------------------------------------------
    // Stimulus and checks
    // ----------------------------------------------
    typedef struct packed {
        logic [19:0] pc;
        logic ext, len, bw;
        logic [1:0] sm;
        logic [3:0] sr;
        logic dm;
        logic [3:0] dr, shi, dhi;
        logic [15:0] six, dix;
        logic [19:0] sea, dea;
        logic [2:0] words;
    } pra_row_type;
    logic clock = 1'h0;
    logic rst_b = 1'h0;
    logic start = 1'h0;
    logic [19:0] program_counter = 20'h0_0000;
    logic is_extended = 1'h0, len_flag = 1'h0, byte_word = 1'h0, dst_mode = 1'h0;
    logic [1:0] src_mode = 2'h0;
    logic [3:0] src_reg = 4'h0, dst_reg = 4'h0, src_index_hi = 4'h0, dst_index_hi = 4'h0;
    logic [3:0] wait_cycles = 4'h0;
    logic busy, mem_req, mem_ack, done, src_valid, dst_valid;
    logic [19:0] mem_addr, src_addr, dst_addr, src_operand, dst_operand;
    logic [15:0] mem_rdata;
    logic [2:0] insn_words;
    int failures = 0;
    int check_count = 0;
    int cycle_count = 0;
    // Unused upper index bits set to ones on base rows
    pra_row_type rows [9] = '{
        '{20'h0_1034, 0, 0, 0, 1, 0, 1, 0, 15, 15, 16'h4766, 16'hf740, 20'h0_579c, 20'h0_0778, 3},
        '{20'h2_f034, 0, 0, 0, 1, 0, 1, 2, 15, 15, 16'h4766, 16'h0778, 20'h3_379c, 20'h0_0778, 3},
        '{20'h2_1034, 1, 1, 1, 1, 0, 1, 0, 1, 5, 16'h4766, 16'h6740, 20'h3_579c, 20'h7_7778, 4},
        '{20'h2_1034, 1, 0, 1, 1, 2, 1, 2, 3, 7, 16'h579c, 16'h7778, 20'h3_579c, 20'h7_7778, 4},
        '{20'h1_0000, 0, 0, 0, 1, 0, 0, 0, 15, 15, 16'h8000, 0, 20'h0_8002, 0, 2},
        '{20'h0_fff0, 0, 0, 0, 1, 0, 0, 0, 15, 15, 16'h0100, 0, 20'h0_00f2, 0, 2},
        '{20'h2_f034, 0, 0, 0, 1, 2, 1, 0, 15, 15, 16'hf000, 16'hfff0, 20'h0_f000, 20'h2_f028, 3},
        '{20'h0_2000, 0, 0, 0, 0, 0, 1, 0, 15, 15, 0, 16'h0010, 0, 20'h0_2012, 2},
        '{20'h0_3000, 1, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 2}};

    pra_agu pra_agu_inst (.*);
    pra_mem_model pra_mem_model_inst (.*);

    always #5 clock = ~clock;

    function automatic logic [15:0] dat(input logic [19:0] a);
        return a[15:0] ^ 16'ha5a5;
    endfunction

    function automatic logic [19:0] op(input logic [19:0] a, input logic w);
        logic [15:0] h;
        h = w ? dat(a + 20'h0_0002) : 16'h0;
        return {h[3:0], dat(a)};
    endfunction

    task automatic chk(input string name, input logic [19:0] exp, input logic [19:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic run_row(input pra_row_type r, input int n, input bit poke);
        logic sv;
        logic dv;
        logic w;
        logic [19:0] ea;
        sv = r.sm == 2'h1 && (r.sr == 4'h0 || r.sr == 4'h2);
        dv = r.dm && (r.dr == 4'h0 || r.dr == 4'h2);
        w = r.ext && !r.len && r.bw;
        pra_mem_model_inst.mem.delete();
        for (int k = 0; k < 4; k++) begin
            ea = (k < 2 ? r.sea : r.dea) + 20'(2 * (k % 2));
            pra_mem_model_inst.mem[ea] = dat(ea);
        end
        ea = r.pc + 20'h0_0002;
        if (sv) begin
            pra_mem_model_inst.mem[ea] = r.six;
            ea = ea + 20'h0_0002;
        end
        if (dv) pra_mem_model_inst.mem[ea] = r.dix;
        @(posedge clock);
        wait_cycles <= 4'(3 * (n % 2));
        program_counter <= r.pc;
        {is_extended, len_flag, byte_word} <= {r.ext, r.len, r.bw};
        {src_mode, src_reg, dst_mode, dst_reg} <= {r.sm, r.sr, r.dm, r.dr};
        {src_index_hi, dst_index_hi} <= {r.shi, r.dhi};
        start <= 1'h1;
        @(posedge clock);
        start <= 1'h0;
        if (poke) begin
            @(posedge clock);
            start <= 1'h1;
            program_counter <= 20'h0_5000;
            @(posedge clock);
            start <= 1'h0;
        end
        for (int i = 0; i < 200 && done !== 1'h1; i++) @(negedge clock);
        chk("done", 20'h0_0001, 20'(done));
        chk("src_valid", 20'(sv), 20'(src_valid));
        chk("dst_valid", 20'(dv), 20'(dst_valid));
        chk("insn_words", 20'(r.words), 20'(insn_words));
        if (sv) chk("src_addr", r.sea, src_addr);
        if (dv) chk("dst_addr", r.dea, dst_addr);
        if (sv) chk("src_operand", op(r.sea, w), src_operand);
        if (dv) chk("dst_operand", op(r.dea, w), dst_operand);
        $display("test %0d done", n);
    endtask

    always @(posedge clock) begin
        cycle_count++;
        if (cycle_count == 3000) begin
            failures++;
            give_verdict();
        end
    end

    initial begin
        repeat (5) @(posedge clock);
        chk("insn_words in reset", 20'h0, 20'(insn_words));
        $display("test reset done");
        rst_b <= 1'h1;
        foreach (rows[i]) run_row(rows[i], i, 0);
        run_row(rows[0], 9, 1);
        @(posedge clock);
        start <= 1'h1;
        @(posedge clock);
        start <= 1'h0;
        repeat (3) @(posedge clock);
        rst_b <= 1'h0;
        @(negedge clock);
        chk("mem_req in reset", 20'h0, 20'({busy, mem_req, done, src_valid}));
        $display("test 10 done");
        @(posedge clock);
        rst_b <= 1'h1;
        run_row(rows[3], 11, 0);
        give_verdict();
    end
endmodule

`default_nettype wire
